/* pkg/stc_consts.svh */
/*
 constants for the transparent serial channel: register offsets, field positions,
 descriptor layout and timing. assumes inclusion by bare name.
*/
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH
`define STC_OFF_MODE      4'h0
`define STC_OFF_EVENT     4'h1
`define STC_OFF_MASK      4'h2
`define STC_OFF_CMD       4'h3
`define STC_OFF_RXBASE    4'h4
`define STC_OFF_TXBASE    4'h5
`define STC_OFF_MAXRX     4'h6
`define STC_OFF_STAT      4'h7
`define STC_MODE_RST      16'h0000
`define STC_MODE_REN      0
`define STC_MODE_TEN      1
`define STC_MODE_DM_LO    2
`define STC_MODE_SM_LO    4
`define STC_SM_TRANSP     2'h3
`define STC_DM_NORMAL     2'h0
`define STC_DM_LOOP       2'h1
`define STC_DM_ECHO       2'h2
`define STC_EV_RX         0
`define STC_EV_TX         1
`define STC_EV_BSY        2
`define STC_EV_TXE        4
`define STC_EV_MASKBITS   8'h17
`define STC_BD_E          15
`define STC_BD_W          13
`define STC_BD_I          12
`define STC_BD_L          11
`define STC_BD_CM         9
`define STC_BD_ERR        1
`define STC_BD_LEN_OFF    32'h2
`define STC_BD_PTR_OFF    32'h4
`define STC_BD_SIZE       32'h8
`define STC_CMD_HUNT      8'h01
`define STC_CMD_STOPTX    8'h02
`define STC_CMD_RESTART   8'h04
`define STC_TEN_GAP_CLKS  3'd3
`define STC_CHAR_BITS     4'd8
`endif

/* pkg/stc_pkg.sv */
/*
 types for the transparent serial channel. assumes stc_consts.svh alongside.
*/
package stc_pkg;
  typedef enum logic [2:0] {
    STC_TX_IDLE  = 3'b000,
    STC_TX_STAT  = 3'b001,
    STC_TX_LEN   = 3'b011,
    STC_TX_PTR   = 3'b010,
    STC_TX_DATA  = 3'b110,
    STC_TX_SHIFT = 3'b111,
    STC_TX_CLOSE = 3'b101
  } stc_tx_st_t;
  typedef enum logic [2:0] {
    STC_RX_IDLE  = 3'b000,
    STC_RX_STAT  = 3'b001,
    STC_RX_LEN   = 3'b011,
    STC_RX_PTR   = 3'b010,
    STC_RX_WAIT  = 3'b110,
    STC_RX_WDAT  = 3'b111,
    STC_RX_CLEN  = 3'b101,
    STC_RX_CST   = 3'b100
  } stc_rx_st_t;
endpackage : stc_pkg

/* hw/stc_channel.sv */
/*
 transparent serial channel with buffer descriptors, avalon-mm register slave and
 a simple 16-bit memory master for descriptor tables and buffers.
 assumes: serial clock and data come from outside and are sampled on sys_clk;
 the memory port answers a request with mem_ack after any number of cycles.
*/
`timescale 1ns/100ps
`include "stc_consts.svh"
module stc_channel import stc_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        ser_clk,
  input  wire logic        ser_sync_n,
  input  wire logic        ser_rxd,
  output logic             ser_txd,
  output logic             irq
);
  logic [15:0] mode_ff;
  logic [7:0]  event_ff, mask_ff;
  logic [15:0] rxbase_ff, txbase_ff, maxrx_ff;
  logic        rd_ack_ff;
  logic [1:0]  clk_s_ff, sync_s_ff, rxd_s_ff;
  logic        clk_d_ff, sync_d_ff;
  logic        hunt_req_ff, stop_ff;
  logic [2:0]  ten_gap_ff;
  logic        ten_allowed;
  logic        rise, sync_fall, transp, tx_enable_bit, ren, rxbit;
  logic [1:0]  dm;
  stc_tx_st_t  tx_st_ff;
  stc_rx_st_t  rx_st_ff;
  logic [15:0] tx_bdp_ff, tx_stat_ff, tx_len_ff, tx_cnt_ff;
  logic [31:0] tx_ptr_ff;
  logic [7:0]  tx_sh_ff;
  logic [3:0]  tx_bit_ff;
  logic        tx_synced_ff, tx_err_ff;
  logic [15:0] rx_bdp_ff, rx_stat_ff, rx_cnt_ff;
  logic [31:0] rx_ptr_ff;
  logic [7:0]  rx_sh_ff, rx_hold_ff;
  logic [3:0]  rx_bit_ff;
  logic        rx_full_ff, rx_ovr_ff, rx_synced_ff, rx_close_ff;
  logic        tx_mem, rx_mem;
  logic [7:0]  ev_set, ev_clr;
  logic        wr_hit;
  logic        txd_raw;

  // serial inputs pass two flops first
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      clk_s_ff  <= 2'h3;
      sync_s_ff <= 2'h3;
      rxd_s_ff  <= 2'h3;
      clk_d_ff  <= 1'b1;
      sync_d_ff <= 1'b1;
    end else begin
      clk_s_ff  <= {clk_s_ff[0], ser_clk};
      sync_s_ff <= {sync_s_ff[0], ser_sync_n};
      rxd_s_ff  <= {rxd_s_ff[0], ser_rxd};
      clk_d_ff  <= clk_s_ff[1];
      sync_d_ff <= sync_s_ff[1];
    end
  end
  assign rise      = clk_s_ff[1] & ~clk_d_ff;
  assign sync_fall = ~sync_s_ff[1] & sync_d_ff;
  assign transp = mode_ff[`STC_MODE_SM_LO +: 2] == `STC_SM_TRANSP;
  assign dm     = mode_ff[`STC_MODE_DM_LO +: 2];
  assign tx_enable_bit    = transp & mode_ff[`STC_MODE_TEN] & ~stop_ff;
  assign ren    = transp & mode_ff[`STC_MODE_REN];
  // loopback feeds own output back; echo and normal take the pin
  assign rxbit  = (dm == `STC_DM_LOOP) ? txd_raw : rxd_s_ff[1];
  assign ser_txd = (dm == `STC_DM_ECHO) ? rxd_s_ff[1] : txd_raw;
  assign ten_allowed = ten_gap_ff == 3'd0;

  // register slave, one wait state on read, none on write
  assign avs_waitrequest = avs_read & ~rd_ack_ff;
  assign wr_hit = avs_write;
  always_ff @(posedge sys_clk) begin
    if (!resetn) rd_ack_ff <= 1'b0;
    else         rd_ack_ff <= avs_read & ~rd_ack_ff;
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) avs_readdata <= 32'h0;
    else if (avs_read & ~rd_ack_ff) begin
      unique case (avs_address)
        `STC_OFF_MODE:   avs_readdata <= {16'h0, mode_ff};
        `STC_OFF_EVENT:  avs_readdata <= {24'h0, event_ff};
        `STC_OFF_MASK:   avs_readdata <= {24'h0, mask_ff};
        `STC_OFF_RXBASE: avs_readdata <= {16'h0, rxbase_ff};
        `STC_OFF_TXBASE: avs_readdata <= {16'h0, txbase_ff};
        `STC_OFF_MAXRX:  avs_readdata <= {16'h0, maxrx_ff};
        `STC_OFF_STAT:   avs_readdata <= {24'h0, 1'b0, rx_st_ff, 1'b0, tx_st_ff};
        default:         avs_readdata <= 32'h0;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mode_ff   <= `STC_MODE_RST;
      mask_ff   <= 8'h00;
      rxbase_ff <= 16'h0;
      txbase_ff <= 16'h0;
      maxrx_ff  <= 16'h0;
    end else if (wr_hit) begin
      unique case (avs_address)
        // a re-enable inside the gap is held off
        `STC_OFF_MODE: mode_ff <= {avs_writedata[15:2],
                                   avs_writedata[`STC_MODE_TEN] & ten_allowed,
                                   avs_writedata[`STC_MODE_REN]};
        `STC_OFF_MASK:   mask_ff   <= avs_writedata[7:0] & `STC_EV_MASKBITS;
        `STC_OFF_RXBASE: rxbase_ff <= avs_writedata[15:0];
        `STC_OFF_TXBASE: txbase_ff <= avs_writedata[15:0];
        `STC_OFF_MAXRX:  maxrx_ff  <= avs_writedata[15:0];
        default: ;
      endcase
    end
  end
  // counts serial clocks after transmit disable
  always_ff @(posedge sys_clk) begin
    if (!resetn) ten_gap_ff <= 3'd0;
    else if (wr_hit && avs_address == `STC_OFF_MODE && mode_ff[`STC_MODE_TEN]
             && !avs_writedata[`STC_MODE_TEN]) ten_gap_ff <= `STC_TEN_GAP_CLKS;
    else if (rise && ten_gap_ff != 3'd0) ten_gap_ff <= ten_gap_ff - 3'd1;
  end
  // commands: hunt held until rx waits or is disabled, stop/restart hold
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hunt_req_ff <= 1'b0;
      stop_ff     <= 1'b0;
    end else begin
      if (wr_hit && avs_address == `STC_OFF_CMD && (avs_writedata[7:0] & `STC_CMD_HUNT) != 8'h0)
        hunt_req_ff <= 1'b1;
      else if (rx_st_ff == STC_RX_WAIT || !ren) hunt_req_ff <= 1'b0;
      if (wr_hit && avs_address == `STC_OFF_CMD && (avs_writedata[7:0] & `STC_CMD_STOPTX) != 8'h0)
        stop_ff <= 1'b1;
      else if (wr_hit && avs_address == `STC_OFF_CMD &&
               (avs_writedata[7:0] & `STC_CMD_RESTART) != 8'h0) stop_ff <= 1'b0;
    end
  end

  // events: set wins over write-one clear
  assign ev_clr = (wr_hit && avs_address == `STC_OFF_EVENT) ? avs_writedata[7:0] : 8'h00;
  always_ff @(posedge sys_clk) begin
    if (!resetn) event_ff <= 8'h00;
    else event_ff <= ((event_ff & ~ev_clr) | ev_set) & `STC_EV_MASKBITS;
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) irq <= 1'b0;
    else irq <= |(event_ff & mask_ff);
  end

  // memory port: tx has priority whenever both wait
  assign tx_mem = tx_st_ff inside {STC_TX_STAT, STC_TX_LEN, STC_TX_PTR, STC_TX_DATA,
                                   STC_TX_CLOSE};
  assign rx_mem = rx_st_ff inside {STC_RX_STAT, STC_RX_LEN, STC_RX_PTR, STC_RX_WDAT,
                                   STC_RX_CLEN, STC_RX_CST};
  always_comb begin
    mem_req   = tx_mem | rx_mem;
    mem_we    = 1'b0;
    mem_addr  = 32'h0;
    mem_wdata = 16'h0;
    if (tx_mem) begin
      unique case (tx_st_ff)
        STC_TX_STAT:  mem_addr = {16'h0, tx_bdp_ff};
        STC_TX_LEN:   mem_addr = {16'h0, tx_bdp_ff} + `STC_BD_LEN_OFF;
        STC_TX_PTR:   mem_addr = {16'h0, tx_bdp_ff} + `STC_BD_PTR_OFF;
        STC_TX_DATA:  mem_addr = tx_ptr_ff + {16'h0, tx_cnt_ff};
        default: begin
          mem_we    = 1'b1;
          mem_addr  = {16'h0, tx_bdp_ff};
          // final status stands for the whole request
          mem_wdata = tx_stat_ff;
          mem_wdata[`STC_BD_ERR] = tx_err_ff;
          mem_wdata[`STC_BD_E] = tx_stat_ff[`STC_BD_CM] & ~tx_err_ff;
        end
      endcase
    end else if (rx_mem) begin
      unique case (rx_st_ff)
        STC_RX_STAT: mem_addr = {16'h0, rx_bdp_ff};
        STC_RX_LEN:  mem_addr = {16'h0, rx_bdp_ff} + `STC_BD_LEN_OFF;
        STC_RX_PTR:  mem_addr = {16'h0, rx_bdp_ff} + `STC_BD_PTR_OFF;
        STC_RX_WDAT: begin
          mem_we = 1'b1;
          mem_addr = rx_ptr_ff + {16'h0, rx_cnt_ff};
          mem_wdata = {8'h00, rx_hold_ff};
        end
        STC_RX_CLEN: begin
          mem_we = 1'b1;
          mem_addr = {16'h0, rx_bdp_ff} + `STC_BD_LEN_OFF;
          mem_wdata = rx_cnt_ff;
        end
        default: begin
          mem_we = 1'b1;
          mem_addr = {16'h0, rx_bdp_ff};
          mem_wdata = rx_stat_ff;
        end
      endcase
    end
  end

  // transmitter: fetch descriptor, send bytes msb first on serial clock rises
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_st_ff <= STC_TX_IDLE;
      tx_bdp_ff <= 16'h0;
      tx_stat_ff <= 16'h0;
      tx_len_ff <= 16'h0;
      tx_cnt_ff <= 16'h0;
      tx_ptr_ff <= 32'h0;
      tx_sh_ff <= 8'hff;
      tx_bit_ff <= 4'h0;
      tx_synced_ff <= 1'b0;
      tx_err_ff <= 1'b0;
      txd_raw <= 1'b1;
    end else begin
      if (rise) txd_raw <= tx_st_ff == STC_TX_SHIFT ? tx_sh_ff[7] : 1'b1;
      if (!tx_enable_bit) begin
        tx_st_ff <= STC_TX_IDLE;
        tx_synced_ff <= 1'b0;
        if (!transp || !mode_ff[`STC_MODE_TEN]) tx_bdp_ff <= txbase_ff;
      end else begin
        if (sync_fall) tx_synced_ff <= 1'b1;
        unique case (tx_st_ff)
          STC_TX_IDLE: if (tx_synced_ff) tx_st_ff <= STC_TX_STAT;
          STC_TX_STAT: if (mem_ack) begin
            tx_stat_ff <= mem_rdata;
            tx_st_ff <= mem_rdata[`STC_BD_E] ? STC_TX_LEN : STC_TX_IDLE;
          end
          STC_TX_LEN: if (mem_ack) begin
            tx_len_ff <= mem_rdata;
            tx_st_ff <= STC_TX_PTR;
          end
          STC_TX_PTR: if (mem_ack) begin
            tx_ptr_ff <= {16'h0, mem_rdata};
            tx_cnt_ff <= 16'h0;
            tx_err_ff <= 1'b0;
            tx_st_ff <= tx_len_ff == 16'h0 ? STC_TX_CLOSE : STC_TX_DATA;
          end
          STC_TX_DATA: begin
            if (mem_ack) begin
              tx_sh_ff <= mem_rdata[7:0];
              tx_bit_ff <= `STC_CHAR_BITS;
              tx_cnt_ff <= tx_cnt_ff + 16'h1;
              tx_st_ff <= STC_TX_SHIFT;
            end else if (rise && tx_cnt_ff != 16'h0 && tx_bit_ff == 4'h0) begin
              tx_err_ff <= 1'b1;
              tx_st_ff <= STC_TX_CLOSE;
            end
          end
          STC_TX_SHIFT: if (rise) begin
            tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
            tx_bit_ff <= tx_bit_ff - 4'h1;
            if (tx_bit_ff == 4'h1)
              tx_st_ff <= tx_cnt_ff == tx_len_ff ? STC_TX_CLOSE : STC_TX_DATA;
          end
          default: if (mem_ack) begin
            if (tx_stat_ff[`STC_BD_L]) tx_synced_ff <= 1'b0;
            tx_bdp_ff <= tx_stat_ff[`STC_BD_W] ? txbase_ff
                         : tx_bdp_ff + 16'(`STC_BD_SIZE);
            tx_st_ff <= STC_TX_IDLE;
          end
        endcase
        if (tx_st_ff == STC_TX_PTR || tx_st_ff == STC_TX_STAT)
          tx_stat_ff[`STC_BD_ERR] <= tx_st_ff == STC_TX_STAT ? mem_rdata[`STC_BD_ERR] : 1'b0;
        if (tx_st_ff == STC_TX_CLOSE && !mem_ack) begin
          tx_stat_ff[`STC_BD_ERR] <= tx_err_ff;
          tx_stat_ff[`STC_BD_E] <= tx_stat_ff[`STC_BD_CM] & ~tx_err_ff;
        end
        if (tx_st_ff == STC_TX_CLOSE && mem_ack && tx_err_ff) tx_synced_ff <= 1'b0;
      end
    end
  end

  // receiver: assemble bytes, store, close on full, overrun or hunt
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_st_ff <= STC_RX_IDLE;
      rx_bdp_ff <= 16'h0;
      rx_stat_ff <= 16'h0;
      rx_cnt_ff <= 16'h0;
      rx_ptr_ff <= 32'h0;
      rx_sh_ff <= 8'h0;
      rx_hold_ff <= 8'h0;
      rx_bit_ff <= 4'h0;
      rx_full_ff <= 1'b0;
      rx_ovr_ff <= 1'b0;
      rx_synced_ff <= 1'b0;
      rx_close_ff <= 1'b0;
    end else if (!ren) begin
      rx_st_ff <= STC_RX_IDLE;
      rx_synced_ff <= 1'b0;
      rx_full_ff <= 1'b0;
      rx_bdp_ff <= rxbase_ff;
    end else begin
      if (sync_fall) rx_synced_ff <= 1'b1;
      if (hunt_req_ff) rx_synced_ff <= 1'b0;
      if (rise && rx_synced_ff && !hunt_req_ff) begin
        rx_sh_ff <= {rx_sh_ff[6:0], rxbit};
        rx_bit_ff <= rx_bit_ff == `STC_CHAR_BITS - 4'h1 ? 4'h0 : rx_bit_ff + 4'h1;
        if (rx_bit_ff == `STC_CHAR_BITS - 4'h1) begin
          rx_hold_ff <= {rx_sh_ff[6:0], rxbit};
          if (rx_full_ff) rx_ovr_ff <= 1'b1;
          rx_full_ff <= 1'b1;
        end
      end
      unique case (rx_st_ff)
        STC_RX_IDLE: if (rx_full_ff || rx_synced_ff) rx_st_ff <= STC_RX_STAT;
        STC_RX_STAT: if (mem_ack & ~tx_mem) begin
          rx_stat_ff <= mem_rdata;
          if (mem_rdata[`STC_BD_E]) rx_st_ff <= STC_RX_PTR;
          else begin
            rx_st_ff <= STC_RX_IDLE;
            rx_full_ff <= 1'b0;
          end
        end
        STC_RX_PTR: if (mem_ack & ~tx_mem) begin
          rx_ptr_ff <= {16'h0, mem_rdata};
          rx_cnt_ff <= 16'h0;
          rx_ovr_ff <= 1'b0;
          rx_close_ff <= 1'b0;
          rx_st_ff <= STC_RX_WAIT;
        end
        STC_RX_WAIT: begin
          if (hunt_req_ff && rx_cnt_ff != 16'h0) rx_st_ff <= STC_RX_CLEN;
          else if (rx_full_ff) rx_st_ff <= STC_RX_WDAT;
        end
        STC_RX_WDAT: if (mem_ack & ~tx_mem) begin
          rx_full_ff <= 1'b0;
          rx_cnt_ff <= rx_cnt_ff + 16'h1;
          if (rx_ovr_ff || rx_cnt_ff + 16'h1 >= maxrx_ff) rx_st_ff <= STC_RX_CLEN;
          else rx_st_ff <= STC_RX_WAIT;
        end
        STC_RX_CLEN: if (mem_ack & ~tx_mem) begin
          rx_stat_ff[`STC_BD_ERR] <= rx_ovr_ff;
          rx_stat_ff[`STC_BD_E] <= rx_stat_ff[`STC_BD_CM] & ~rx_ovr_ff;
          rx_st_ff <= STC_RX_CST;
        end
        STC_RX_CST: if (mem_ack & ~tx_mem) begin
          rx_bdp_ff <= rx_stat_ff[`STC_BD_W] ? rxbase_ff
                       : rx_bdp_ff + 16'(`STC_BD_SIZE);
          rx_close_ff <= 1'b1;
          rx_st_ff <= STC_RX_IDLE;
        end
        default: rx_st_ff <= STC_RX_IDLE;
      endcase
    end
  end

  // event sources
  always_comb begin
    ev_set = 8'h00;
    if (rx_st_ff == STC_RX_CST && mem_ack && !tx_mem && rx_stat_ff[`STC_BD_I])
      ev_set[`STC_EV_RX] = 1'b1;
    if (rx_st_ff == STC_RX_STAT && mem_ack && !tx_mem && !mem_rdata[`STC_BD_E] && rx_full_ff)
      ev_set[`STC_EV_BSY] = 1'b1;
    if (tx_st_ff == STC_TX_CLOSE && mem_ack && tx_stat_ff[`STC_BD_I] && tx_err_ff)
      ev_set[`STC_EV_TXE] = 1'b1;
    if (tx_stat_ff[`STC_BD_I] && !tx_err_ff && tx_enable_bit) begin
      if (tx_stat_ff[`STC_BD_L] && tx_st_ff == STC_TX_SHIFT && rise && tx_cnt_ff == tx_len_ff
          && tx_bit_ff == `STC_CHAR_BITS) ev_set[`STC_EV_TX] = 1'b1;
      // count still lags by one while the last character is fetched
      if (!tx_stat_ff[`STC_BD_L] && tx_st_ff == STC_TX_DATA && mem_ack
          && tx_cnt_ff + 16'h1 == tx_len_ff) ev_set[`STC_EV_TX] = 1'b1;
    end
  end

  irq_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 irq == |($past(event_ff) & $past(mask_ff)))
    else $error("irq does not follow unmasked events");
  event_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wr_hit && avs_address == `STC_OFF_EVENT && avs_writedata[0] && ev_set[0] == 1'b0)
    |=> !event_ff[0]) else $error("rx event not cleared");
  event_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ev_set[`STC_EV_TX] |=> event_ff[`STC_EV_TX]) else $error("tx event lost");
  rsvd_events_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (event_ff & ~`STC_EV_MASKBITS) == 8'h00) else $error("reserved event bit set");
  rx_owner_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rx_st_ff == STC_RX_STAT && mem_ack && !tx_mem && !mem_rdata[`STC_BD_E])
    |=> rx_st_ff == STC_RX_IDLE) else $error("rx used non-empty descriptor");
  rx_cm_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rx_st_ff == STC_RX_CST && mem_req && !tx_mem) |-> mem_wdata[`STC_BD_E] ==
    (rx_stat_ff[`STC_BD_CM] & ~rx_stat_ff[`STC_BD_ERR]))
    else $error("rx empty bit wrong on close");
  tx_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tx_st_ff == STC_TX_SHIFT || tx_st_ff == STC_TX_DATA) |-> tx_cnt_ff <= tx_len_ff)
    else $error("tx sent beyond length");
  tx_close_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tx_st_ff == STC_TX_CLOSE && mem_req) |-> mem_we && mem_wdata[`STC_BD_E] ==
    (tx_stat_ff[`STC_BD_CM] & ~tx_err_ff) && mem_wdata[`STC_BD_ERR] == tx_err_ff)
    else $error("tx ready bit wrong on close");
  ten_gap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ten_gap_ff != 3'd0) |=> !mode_ff[`STC_MODE_TEN]) else $error("tx re-enabled early");
  idle_mode_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !transp |=> tx_st_ff == STC_TX_IDLE && rx_st_ff == STC_RX_IDLE)
    else $error("channel active outside transparent mode");
  rx_done_cov: cover property (@(posedge sys_clk) disable iff (!resetn) ev_set[`STC_EV_RX]);
  tx_done_cov: cover property (@(posedge sys_clk) disable iff (!resetn) ev_set[`STC_EV_TX]);
  tx_err_cov: cover property (@(posedge sys_clk) disable iff (!resetn) ev_set[`STC_EV_TXE]);
  busy_cov: cover property (@(posedge sys_clk) disable iff (!resetn) ev_set[`STC_EV_BSY]);
endmodule : stc_channel

/* tb/stc_mem_model.sv */
/*
 memory holding descriptor tables and buffers, 16-bit words at byte addresses.
 assumes the channel holds mem_req with address until mem_ack; slow adds wait states.
*/
`timescale 1ns/100ps
module stc_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack,
  input  wire logic        slow
);
  logic [15:0] store_ff [0:4095];
  logic [1:0]  wait_ff;
  always @(posedge sys_clk) begin
    mem_ack   <= 1'b0;
    // read data not held past the ack cycle
    mem_rdata <= ~mem_rdata;
    if (!resetn) begin
      wait_ff   <= 2'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack) begin
      if (wait_ff == 2'h0) begin
        mem_ack <= 1'b1;
        wait_ff <= slow ? 2'h3 : 2'h0;
        if (mem_we) store_ff[mem_addr[11:0]] <= mem_wdata;
        else mem_rdata <= store_ff[mem_addr[11:0]];
      end else wait_ff <= wait_ff - 2'h1;
    end
  end
endmodule : stc_mem_model

/* tb/testbench.sv */
/*
 self-checking bench: avalon register access, one frame of serial rx and tx.
 assumes the channel and memory model as declared; serial clock made here.
*/
`timescale 1ns/100ps
`include "stc_consts.svh"
module testbench import stc_pkg::*;;
  logic sys_clk = 0, resetn = 0, avs_read = 0, avs_write = 0, avs_waitrequest, irq;
  logic [3:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, mem_addr, q, rxw, seed = 32'ha6296f6c;
  logic mem_req, mem_we, mem_ack, ser_txd, ser_clk = 1, ser_sync_n = 1, ser_rxd = 1;
  logic ser_run = 0, slow = 0, hit;
  logic [15:0] mem_wdata, mem_rdata, v;
  logic [7:0] tb [0:2];
  logic [63:0] cap = 0;
  int errors = 0, n_compared = 0;
  stc_channel i_dut (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .ser_clk(ser_clk), .ser_sync_n(ser_sync_n), .ser_rxd(ser_rxd),
    .ser_txd(ser_txd), .irq(irq));
  stc_mem_model i_mem (.sys_clk(sys_clk), .resetn(resetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .slow(slow));
  initial forever #4 sys_clk = ~sys_clk;
  initial begin
    #3.3;
    forever #62.5 ser_clk = ser_run ? ~ser_clk : 1'b1;
  end
  always @(posedge ser_clk) cap <= {cap[62:0], ser_txd};
  task automatic bus(input logic [3:0] a, input logic we, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 0);
    chk(q, exp);
  endtask : rdc
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    #500000;
    errors++;
    conclude();
  end
  initial begin
    rxw = $random(seed);
    i_mem.store_ff[12'h000] = 16'hb000;
    i_mem.store_ff[12'h004] = 16'h0300; // even rx pointer
    i_mem.store_ff[12'h100] = 16'hb800;
    i_mem.store_ff[12'h102] = 16'h0003;
    i_mem.store_ff[12'h104] = 16'h0201; // odd pointer, 8-bit chars
    for (int i = 0; i < 3; i++) begin
      tb[i] = $random(seed);
      i_mem.store_ff[12'h201 + i] = {8'h00, tb[i]};
    end
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc(`STC_OFF_MODE, 0);
    rdc(`STC_OFF_EVENT, 0);
    rdc(`STC_OFF_MASK, 0);
    rdc(4'hf, 0);
    for (int i = 0; i < 3; i++) begin
      v = ($random(seed) & 16'h0031) | 16'(i << 2);
      bus(`STC_OFF_MODE, 1'b1, {16'h0, v});
      rdc(`STC_OFF_MODE, {16'h0, v});
    end
    bus(`STC_OFF_MODE, 1'b1, 32'h0033);
    bus(`STC_OFF_MODE, 1'b1, 32'h0031);
    bus(`STC_OFF_MODE, 1'b1, 32'h0033);
    rdc(`STC_OFF_MODE, 32'h0031);
    $display("register test done");
    bus(`STC_OFF_MODE, 1'b1, 32'h0030);
    bus(`STC_OFF_RXBASE, 1'b1, 32'h0);
    bus(`STC_OFF_TXBASE, 1'b1, 32'h100);
    bus(`STC_OFF_MAXRX, 1'b1, 32'h4);
    bus(`STC_OFF_MASK, 1'b1, 32'h03);
    slow <= 1'b1;
    ser_run = 1;
    repeat (8) @(negedge ser_clk);
    bus(`STC_OFF_MODE, 1'b1, 32'h0033);
    @(negedge ser_clk) ser_sync_n <= 1'b0;
    // first bit stands with the sync fall, sampled at the next rise
    for (int i = 31; i >= 0; i--) begin
      ser_rxd <= rxw[i];
      @(negedge ser_clk);
      ser_sync_n <= 1'b1;
    end
    for (int i = 0; i < 16; i++) begin
      ser_rxd <= ~ser_rxd;
      @(negedge ser_clk);
    end
    ser_run = 0;
    hit = 0;
    for (int k = 0; k <= 40; k++) if (cap[k+:24] === {tb[0], tb[1], tb[2]}) hit = 1;
    chk(hit, 1);
    chk(i_mem.store_ff[12'h102], 3);
    chk(i_mem.store_ff[12'h100], 32'h3800);
    chk(i_mem.store_ff[12'h000], 32'h3000);
    chk(i_mem.store_ff[12'h002], 4);
    for (int i = 0; i < 4; i++) chk(i_mem.store_ff[12'h300 + i], rxw[31 - 8*i -: 8]);
    rdc(`STC_OFF_EVENT, 32'h07);
    chk(irq, 1);
    $display("frame test done");
    bus(`STC_OFF_EVENT, 1'b1, 32'h01);
    rdc(`STC_OFF_EVENT, 32'h06);
    bus(`STC_OFF_MASK, 1'b1, 32'h01);
    repeat (2) @(posedge sys_clk);
    chk(irq, 0);
    bus(`STC_OFF_EVENT, 1'b1, 32'h06);
    rdc(`STC_OFF_EVENT, 0);
    $display("event test done");
    bus(`STC_OFF_MODE, 1'b1, 32'h0038);
    ser_rxd <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(ser_txd, 0);
    $display("echo test done");
    conclude();
  end
endmodule : testbench
